//--- sbcs_regs.vh
// Purpose: Constants for the spectral bank conversion sequencer
// Assumes: core_clk at 100 MHz, one clock domain
// Notes:   Bank mode codes, timing counts and channel indices
//
// What this block does
// - Each channel integrates photodiode current into a 16-bit conversion count.
// - At cycle end each channel result moves into its result register.
// - Results are double-buffered so a read never mixes two conversions.
// - First photodiode group gives X, Y, Z and near-infrared from one integration.
// - Second photodiode group gives X, Y, dark and clear results.
// - Both groups needed means a second full period; six channels after two.
// - Single-group integration period is never shorter than 2.8 ms.
// - Mode 0 converts continuously, presenting X, Y, Z, near-infrared.
// - Mode 1 converts continuously, presenting X, Y, dark, clear.
// - Mode 2 converts continuously, all six channels after two periods.
// - Modes 2 and 3 also provide calibrated corrected results; here only calibrated_valid is raised, result words stay raw counts.
// - Continuous modes give fresh results each period (each two periods in mode 2) with no host action.
// - Mode 3 starts a one-shot giving all six results together.
// - Data-ready flag goes to 1 when the selected results are available.
// - Writing mode 3 starts exactly one cycle; another one-shot needs rewrite.
// - With interrupt enabled and results ready, interrupt output goes low.
// - Reading the control register releases the interrupt output high.
// - Reading any of the six result registers clears data-ready.
`ifndef SBCS_REGS_VH
`define SBCS_REGS_VH

`define SBCS_MODE_W        2
`define SBCS_MODE_XYZN     2'h0
`define SBCS_MODE_XYDC     2'h1
`define SBCS_MODE_ALL      2'h2
`define SBCS_MODE_ONESHOT  2'h3

`define SBCS_CLK_MHZ       100
`define SBCS_PERIOD_MIN_US  2800
`define SBCS_PERIOD_MIN_CYC (`SBCS_PERIOD_MIN_US * `SBCS_CLK_MHZ)
`define SBCS_PERIOD_RST_CYC 32'h0004_45C0

`define SBCS_CH_X          3'h0
`define SBCS_CH_Y          3'h1
`define SBCS_CH_Z          3'h2
`define SBCS_CH_NEAR_IR    3'h3
`define SBCS_CH_D          3'h4
`define SBCS_CH_C          3'h5
`define SBCS_CH_NUM        6

`define SBCS_RES_W         16
`define SBCS_RES_RST       16'h0000

`endif

//--- sbcs_skid.v
// Purpose: Two-entry buffer carrying a completed result group
// Assumes: Single clock, synchronous active-low reset
// Notes:   Ready follows occupancy alone, so the source never sees a loop
`timescale 1ns/1ps
module sbcs_skid #(
  parameter W = 16
) (
  input  wire         core_clk,
  input  wire         rst_b,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] ent0_q;
  reg [W-1:0] ent1_q;
  reg [1:0]   cnt_q;

  wire push;
  wire pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = ent0_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_q  <= 2'h0;
      ent0_q <= {W{1'b0}};
      ent1_q <= {W{1'b0}};
    end else begin
      if (pop) begin
        ent0_q <= (cnt_q == 2'h2) ? ent1_q : in_data;
      end else if (push && cnt_q == 2'h0) begin
        ent0_q <= in_data;
      end
      if (push && ((cnt_q == 2'h2) || (cnt_q == 2'h1 && !pop))) begin
        ent1_q <= in_data;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

endmodule // sbcs_skid

//--- sbcs_seq.v
// Purpose: Photodiode group conversion sequencer with result registers
// Assumes: core_clk at 100 MHz; converters give a current step per cycle
// Notes:   Result words pass through a two-entry buffer before the registers
`timescale 1ns/1ps
`include "sbcs_regs.vh"
module sbcs_seq #(
  parameter RW         = 16,
  parameter PERIOD_MIN = `SBCS_PERIOD_MIN_CYC
) (
  input  wire             core_clk,
  input  wire             rst_b,
  input  wire [1:0]       bank_mode_wr,
  input  wire             bank_mode_we,
  input  wire             int_enable,
  input  wire [31:0]      integration_period,
  input  wire             ctrl_rd,
  input  wire [2:0]       result_sel,
  input  wire             result_rd,
  input  wire [RW-1:0]    pd_current_x,
  input  wire [RW-1:0]    pd_current_y,
  input  wire [RW-1:0]    pd_current_z,
  input  wire [RW-1:0]    pd_current_near_ir,
  input  wire [RW-1:0]    pd_current_d,
  input  wire [RW-1:0]    pd_current_c,
  output reg  [RW-1:0]    result_data,
  output reg  [1:0]       bank_mode,
  output reg              data_ready,
  output reg              int_b,
  output reg              calibrated_valid,
  output reg              conv_busy,
  output reg              active_group
);

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_INT  = 3'b010;
  localparam ST_MOVE = 3'b100;

  reg [2:0]    state_q;
  reg [31:0]   tick_q;
  reg [31:0]   period_q;
  reg          grp_q;
  reg          half_q;
  reg [1:0]    run_mode_q;
  reg          mode_pend_q;
  reg [1:0]    pend_mode_q;
  reg          oneshot_arm_q;
  reg [2:0]    mv_idx_q;
  reg          move_done_q;
  reg [RW-1:0] acc_q [0:`SBCS_CH_NUM-1];
  reg [RW-1:0] res_q [0:`SBCS_CH_NUM-1];
  reg [RW-1:0] shd_q [0:`SBCS_CH_NUM-1];
  reg [5:0]    shd_vld_q;

  integer i;
  integer j;

  // Saturating add keeps a bright channel pinned at full scale, not wrapped
  function [RW-1:0] sat_add;
    input [RW-1:0] a;
    input [RW-1:0] b;
    reg   [RW:0]   s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[RW] ? {RW{1'b1}} : s[RW-1:0];
    end
  endfunction

  function [RW-1:0] pick_cur;
    input [2:0] idx;
    begin
      case (idx)
        `SBCS_CH_X:   pick_cur = pd_current_x;
        `SBCS_CH_Y:   pick_cur = pd_current_y;
        `SBCS_CH_Z:   pick_cur = pd_current_z;
        `SBCS_CH_NEAR_IR: pick_cur = pd_current_near_ir;
        `SBCS_CH_D:   pick_cur = pd_current_d;
        default:      pick_cur = pd_current_c;
      endcase
    end
  endfunction

  // Group membership: X and Y sit in both groups
  function in_group;
    input       g;
    input [2:0] idx;
    begin
      case (idx)
        `SBCS_CH_X, `SBCS_CH_Y:  in_group = 1'b1;
        `SBCS_CH_Z, `SBCS_CH_NEAR_IR: in_group = ~g;
        default:                      in_group = g;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Result word stream into buffer
  wire          buf_in_ready;
  wire          buf_out_valid;
  wire [RW+2:0] buf_out_data;
  wire          mv_valid;
  wire [RW+2:0] mv_data;

  assign mv_valid = (state_q == ST_MOVE) && !move_done_q && in_group(grp_q, mv_idx_q);
  assign mv_data  = {mv_idx_q, acc_q[mv_idx_q]};

  sbcs_skid #(
    .W (RW + 3)
  ) u_buf (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_valid  (mv_valid),
    .in_ready  (buf_in_ready),
    .in_data   (mv_data),
    .out_valid (buf_out_valid),
    .out_ready (1'b1),
    .out_data  (buf_out_data)
  );

  // Effective period never below the single-group floor
  wire [31:0] period_eff = (integration_period < PERIOD_MIN) ? PERIOD_MIN :
                           integration_period;

  wire [1:0]  mode_next = mode_pend_q ? pend_mode_q : run_mode_q;
  wire        last_mv   = (mv_idx_q == 3'h5);
  wire        last_half = (run_mode_q == `SBCS_MODE_XYZN) || (run_mode_q == `SBCS_MODE_XYDC) ||
                          half_q;

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (!rst_b) begin
      state_q       <= ST_IDLE;
      tick_q        <= 32'h0000_0000;
      period_q      <= `SBCS_PERIOD_RST_CYC;
      grp_q         <= 1'b0;
      half_q        <= 1'b0;
      run_mode_q    <= `SBCS_MODE_XYZN;
      mode_pend_q   <= 1'b0;
      pend_mode_q   <= `SBCS_MODE_XYZN;
      oneshot_arm_q <= 1'b0;
      mv_idx_q      <= 3'h0;
      move_done_q   <= 1'b0;
      for (i = 0; i < `SBCS_CH_NUM; i = i + 1) begin
        acc_q[i] <= `SBCS_RES_RST;
      end
    end else begin
      if (bank_mode_we) begin
        mode_pend_q <= 1'b1;
        pend_mode_q <= bank_mode_wr;
        if (bank_mode_wr == `SBCS_MODE_ONESHOT) begin
          oneshot_arm_q <= 1'b1;
        end
      end
      case (state_q)
        ST_IDLE: begin
          if (mode_pend_q || bank_mode_we || run_mode_q != `SBCS_MODE_ONESHOT) begin
            if (!bank_mode_we) begin
              if (mode_next != `SBCS_MODE_ONESHOT || oneshot_arm_q) begin
                run_mode_q    <= mode_next;
                mode_pend_q   <= 1'b0;
                oneshot_arm_q <= 1'b0;
                period_q      <= period_eff;
                tick_q        <= 32'h0000_0000;
                half_q        <= 1'b0;
                grp_q         <= (mode_next == `SBCS_MODE_XYDC);
                state_q       <= ST_INT;
                for (i = 0; i < `SBCS_CH_NUM; i = i + 1) begin
                  acc_q[i] <= `SBCS_RES_RST;
                end
              end
            end
          end
        end
        ST_INT: begin
          for (i = 0; i < `SBCS_CH_NUM; i = i + 1) begin
            if (in_group(grp_q, i[2:0])) begin
              acc_q[i] <= sat_add(acc_q[i], pick_cur(i[2:0]));
            end
          end
          if (tick_q == period_q - 32'h0000_0001) begin
            tick_q      <= 32'h0000_0000;
            mv_idx_q    <= 3'h0;
            move_done_q <= 1'b0;
            state_q     <= ST_MOVE;
          end else begin
            tick_q <= tick_q + 32'h0000_0001;
          end
        end
        ST_MOVE: begin
          if (!move_done_q && (!mv_valid || buf_in_ready)) begin
            if (last_mv) begin
              move_done_q <= 1'b1;
            end
            mv_idx_q <= mv_idx_q + 3'h1;
          end
          if (move_done_q && !buf_out_valid) begin
            for (i = 0; i < `SBCS_CH_NUM; i = i + 1) begin
              if (in_group(grp_q, i[2:0])) begin
                acc_q[i] <= `SBCS_RES_RST;
              end
            end
            if (!last_half) begin
              half_q  <= 1'b1;
              grp_q   <= 1'b1;
              state_q <= ST_INT;
            end else if (run_mode_q == `SBCS_MODE_ONESHOT) begin
              state_q <= ST_IDLE;
            end else if (mode_pend_q && !bank_mode_we) begin
              state_q <= ST_IDLE;
            end else begin
              half_q  <= 1'b0;
              grp_q   <= (run_mode_q == `SBCS_MODE_XYDC);
              period_q <= period_eff;
              state_q <= ST_INT;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // A one-shot write restarts at once; the half-finished set is dropped
      if (bank_mode_we && bank_mode_wr == `SBCS_MODE_ONESHOT && state_q != ST_IDLE) begin
        state_q <= ST_IDLE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shadow then commit: registers see a whole set at once
  wire set_done = (state_q == ST_MOVE) && move_done_q && !buf_out_valid && last_half;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      shd_vld_q <= 6'h00;
      for (j = 0; j < `SBCS_CH_NUM; j = j + 1) begin
        shd_q[j] <= `SBCS_RES_RST;
        res_q[j] <= `SBCS_RES_RST;
      end
    end else begin
      if (buf_out_valid) begin
        shd_q[buf_out_data[RW+2:RW]]     <= buf_out_data[RW-1:0];
        shd_vld_q[buf_out_data[RW+2:RW]] <= 1'b1;
      end
      if (set_done) begin
        for (j = 0; j < `SBCS_CH_NUM; j = j + 1) begin
          if (shd_vld_q[j]) begin
            res_q[j] <= shd_q[j];
          end
        end
        shd_vld_q <= 6'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host-facing flags and read data
  always @(posedge core_clk) begin
    if (!rst_b) begin
      data_ready       <= 1'b0;
      int_b            <= 1'b1;
      result_data      <= `SBCS_RES_RST;
      calibrated_valid <= 1'b0;
      bank_mode        <= `SBCS_MODE_XYZN;
      conv_busy        <= 1'b0;
      active_group     <= 1'b0;
    end else begin
      bank_mode    <= mode_pend_q ? pend_mode_q : run_mode_q;
      conv_busy    <= (state_q != ST_IDLE);
      active_group <= grp_q;
      if (result_rd) begin
        result_data <= res_q[(result_sel > 3'h5) ? 3'h5 : result_sel];
      end
      // Completion wins over a same-cycle read clear
      if (set_done) begin
        data_ready <= 1'b1;
      end else if (result_rd && result_sel <= 3'h5) begin
        data_ready <= 1'b0;
      end
      if (set_done && int_enable) begin
        int_b <= 1'b0;
      end else if (ctrl_rd) begin
        int_b <= 1'b1;
      end
      if (set_done) begin
        calibrated_valid <= (run_mode_q == `SBCS_MODE_ALL) ||
                            (run_mode_q == `SBCS_MODE_ONESHOT);
      end
    end
  end

endmodule // sbcs_seq

//--- sbcs_checker.sv
// Purpose: Port assertions for the conversion sequencer
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only the top module ports
`timescale 1ns/1ps
module sbcs_checker #(
  parameter RW = 16
) (
  input wire          core_clk,
  input wire          rst_b,
  input wire          ctrl_rd,
  input wire          result_rd,
  input wire [2:0]    result_sel,
  input wire          int_enable,
  input wire [RW-1:0] result_data,
  input wire [1:0]    bank_mode,
  input wire          data_ready,
  input wire          int_b,
  input wire          conv_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  a_int_needs_ready: assert property ($fell(int_b) |-> data_ready && $past(int_enable))
    else $error("interrupt without ready");
  a_ready_drops_int: assert property ($rose(data_ready) && $past(int_enable) |-> !int_b)
    else $error("ready without interrupt");
  a_int_holds: assert property (!int_b && !ctrl_rd |=> !int_b)
    else $error("interrupt released early");
  // Same-edge completion wins, so the release is judged only when data_ready does not rise with it
  a_ctrl_releases: assert property (ctrl_rd ##1 !$rose(data_ready) |-> int_b)
    else $error("interrupt not released");
  a_rd_clears: assert property (
    result_rd && result_sel <= 3'h5 ##1 !$rose(data_ready) |-> !data_ready)
    else $error("ready not cleared");
  a_ready_holds: assert property (data_ready && !result_rd |=> data_ready)
    else $error("ready dropped alone");
  a_data_stable: assert property (!result_rd |=> $stable(result_data))
    else $error("result changed without read");
  a_busy_start: assert property ($rose(rst_b) |-> ##[0:3] conv_busy)
    else $error("no start after reset");
  cover property ($fell(int_b));
  cover property ($rose(data_ready) && bank_mode == 2'h3);
  cover property ($fell(conv_busy));
endmodule // sbcs_checker

bind sbcs_seq sbcs_checker #(.RW(RW)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .ctrl_rd(ctrl_rd), .result_rd(result_rd),
  .result_sel(result_sel), .int_enable(int_enable), .result_data(result_data),
  .bank_mode(bank_mode), .data_ready(data_ready), .int_b(int_b), .conv_busy(conv_busy));

//--- sbcs_host.sv
// Purpose: Host model reading control and result registers
// Assumes: Drives at the falling edge of core_clk
// Notes:   Select is scrambled after a read, as a real host would leave it
`timescale 1ns/1ps
module sbcs_host (
  input  wire        core_clk,
  input  wire [15:0] result_data,
  output reg         ctrl_rd,
  output reg         result_rd,
  output reg  [2:0]  result_sel
);
  reg [15:0] rd_val;
  initial begin
    ctrl_rd = 1'b0;
    result_rd = 1'b0;
    result_sel = 3'h0;
    rd_val = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  task read_res(input [2:0] s);
    begin
      @(negedge core_clk);
      result_sel = s;
      result_rd = 1'b1;
      @(negedge core_clk);
      result_rd = 1'b0;
      result_sel = ~s;
      @(negedge core_clk);
      rd_val = result_data;
    end
  endtask
  task read_ctrl;
    begin
      @(negedge core_clk);
      ctrl_rd = 1'b1;
      @(negedge core_clk);
      ctrl_rd = 1'b0;
    end
  endtask
endmodule // sbcs_host

//--- sbcs_seq_tb.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Short minimum period through PERIOD_MIN
// Notes:   Saturating steps give exact counts whatever the cycle count
`timescale 1ns/1ps
`include "sbcs_regs.vh"
module sbcs_seq_tb;
  localparam PER = 200;
  localparam [15:0] H = 16'hFFFF;
  localparam [15:0] L = 16'h0000;
  reg         core_clk, rst_b, mode_we, int_en;
  reg  [1:0]  mode_wr;
  reg  [15:0] cx, cy, cz, cn, cd, cc;
  wire [15:0] rdata;
  wire [1:0]  bmode;
  wire        rdy, int_b, cal, busy, crd, rrd, grp;
  wire [2:0]  rsel;
  integer     error_cnt, n_tests, t, i;
  sbcs_host host (.core_clk(core_clk), .result_data(rdata), .ctrl_rd(crd),
    .result_rd(rrd), .result_sel(rsel));
  sbcs_seq #(.RW(16), .PERIOD_MIN(PER)) uut (.core_clk(core_clk), .rst_b(rst_b),
    .bank_mode_wr(mode_wr), .bank_mode_we(mode_we), .int_enable(int_en),
    .integration_period(32'h0000_000A), .ctrl_rd(crd), .result_sel(rsel),
    .result_rd(rrd), .pd_current_x(cx), .pd_current_y(cy), .pd_current_z(cz),
    .pd_current_near_ir(cn), .pd_current_d(cd), .pd_current_c(cc),
    .result_data(rdata), .bank_mode(bmode), .data_ready(rdy), .int_b(int_b),
    .calibrated_valid(cal), .conv_busy(busy), .active_group(grp));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] seen, input [15:0] want);
    begin
      n_tests = n_tests + 1;
      if (seen !== want) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task chk1(input seen, input want);
    chk({15'h0000, seen}, {15'h0000, want});
  endtask
  task wait_ready;
    begin
      t = 0;
      while (rdy !== 1'b1 && t < 2000) begin
        @(negedge core_clk);
        t = t + 1;
      end
      chk1(rdy, 1'b1);
    end
  endtask
  task read_all(input [95:0] e);
    for (i = 0; i < 6; i = i + 1) begin
      host.read_res(i[2:0]);
      chk(host.rd_val, e[16*i +: 16]);
    end
  endtask
  task set_mode(input [1:0] m);
    begin
      @(negedge core_clk);
      mode_wr = m;
      mode_we = 1'b1;
      @(negedge core_clk);
      mode_we = 1'b0;
    end
  endtask
  // Drops one completed set: waits for data_ready, then clears it with a read of X
  task skip_set;
    begin
      wait_ready;
      host.read_res(3'h0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_mode0;
    begin
      {cc, cd, cn, cz, cy, cx} = {H, H, L, H, L, H};
      wait_ready;
      chk1(int_b, 1'b0);
      host.read_ctrl;
      chk1(int_b, 1'b1);
      chk1(cal, 1'b0);
      chk1(grp, 1'b0);
      read_all({L, L, L, H, L, H});
      chk1(rdy, 1'b0);
      wait_ready;
      chk1(t >= PER - 30 && t <= PER + 40, 1'b1);
      // Clear this ready so the next scenario waits for a fresh set
      host.read_res(3'h0);
    end
  endtask
  task t_mode1;
    begin
      int_en = 1'b0;
      host.read_ctrl;
      {cc, cd, cn, cz, cy, cx} = {L, H, L, L, L, L};
      set_mode(`SBCS_MODE_XYDC);
      skip_set;
      wait_ready;
      chk1(int_b, 1'b1);
      chk1(bmode == `SBCS_MODE_XYDC, 1'b1);
      chk1(grp, 1'b1);
      read_all({L, H, L, H, L, L});
    end
  endtask
  task t_mode2;
    begin
      {cc, cd, cn, cz, cy, cx} = {H, L, H, L, H, H};
      set_mode(`SBCS_MODE_ALL);
      skip_set;
      skip_set;
      wait_ready;
      chk1(t >= 2 * PER - 30 && t <= 2 * PER + 40, 1'b1);
      chk1(cal, 1'b1);
      read_all({H, L, H, L, H, H});
    end
  endtask
  task t_oneshot;
    begin
      {cc, cd, cn, cz, cy, cx} = {L, H, L, H, L, L};
      int_en = 1'b1;
      set_mode(`SBCS_MODE_ONESHOT);
      wait_ready;
      chk1(t >= 2 * PER - 30 && t <= 2 * PER + 40, 1'b1);
      chk1(int_b, 1'b0);
      host.read_ctrl;
      chk1(cal, 1'b1);
      read_all({L, H, L, H, L, L});
      repeat (3 * PER) @(negedge core_clk);
      chk1(rdy, 1'b0);
      chk1(busy, 1'b0);
      set_mode(`SBCS_MODE_ONESHOT);
      wait_ready;
      chk1(t >= 2 * PER - 30 && t <= 2 * PER + 40, 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    begin
      $display("tests=%0d errors=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole run is near seventeen periods; forty periods is a hang
  initial begin
    #(400 * PER);
    error_cnt = error_cnt + 1;
    give_verdict;
  end
  initial begin
    error_cnt = 0;
    n_tests = 0;
    rst_b = 1'b0;
    mode_we = 1'b0;
    mode_wr = 2'h0;
    int_en = 1'b1;
    {cc, cd, cn, cz, cy, cx} = {6{L}};
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    t_mode0;
    t_mode1;
    t_mode2;
    t_oneshot;
    give_verdict;
  end
endmodule // sbcs_seq_tb
